// ===== rtl/pmc_regs.vh
// register offsets, field positions and reset values of the power mode clock controller
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
`define PMC_ADDR_W 8
`define PMC_OFS_PWR_CTRL 8'h87
`define PMC_OFS_CLK_CTRL 8'hD8
`define PMC_OFS_AUX_TWO 8'hF7
`define PMC_OFS_STATUS 8'hE0
`define PMC_OFS_WAKE_EN 8'hE4
`define PMC_OFS_INT_FLAG 8'hE8
`define PMC_OFS_INT_EN 8'hEC
`define PMC_BIT_IDLE 0
`define PMC_BIT_PDOWN 1
`define PMC_BIT_GF0 2
`define PMC_BIT_GF1 3
`define PMC_BIT_BAUD 7
`define PMC_BIT_SLOW_TYPE 7
`define PMC_BIT_FAST_TYPE 6
`define PMC_BIT_SLOW_STOP 5
`define PMC_BIT_PCLK_GATE 4
`define PMC_BIT_FAST_STOP 3
`define PMC_BIT_FAST_SEL 2
`define PMC_BIT_WDT_HI 7
`define PMC_BIT_WDT_LO 6
`define PMC_RST_PWR_CTRL 8'h00
`define PMC_RST_CLK_CTRL 8'h23
`define PMC_RST_AUX_TWO 8'h00
`define PMC_PSC_DIV16 2'h0
`define PMC_PSC_DIV4 2'h1
`define PMC_PSC_DIV2 2'h2
`define PMC_PSC_DIV1 2'h3
`define PMC_PSC_DELAY 5'h10
`define PMC_NUM_SRC 14
`define PMC_NUM_PINS 10
`define PMC_SRC_INT0 0
`define PMC_SRC_INT1 2
`define PMC_SRC_TMR3 7
`define PMC_SRC_PORT1 8
`define PMC_SRC_INT29 9
`endif

// ===== rtl/pmc_top.v
// power mode and system clock controller with avalon-mm register slave
// Behaviour
// - idle request stops cpu, peripherals keep running
// - idle with gate bit stops most peripheral clocks
// - idle ends on reset or enabled interrupt
// - powerdown with slow stop set enters stop
// - stop ends on reset or pin wake
// - powerdown with slow stop clear enters halt
// - halt ends on reset, pin, timer3
// - low enabled pin refuses halt or stop
// - slow type writable only in fast mode
// - fast type writable only in slow mode
// - fast stop writable in slow mode only
// - source select writable only with fast running
// - divider 16/4/2/1, applied within 16 cycles
// - slow stop bit resets to one
// - all enabled wake idle, pins wake powerdown
// - every event sets its flag regardless enable
// - fourteen interrupt sources feed wake logic
// - pin sources: int0, int1, port1, int2-9
// - power control: bit1 powerdown, bit0 idle
// - illegal clock control writes are ignored
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.vh"
module pmc_top #(
  parameter NSRC = `PMC_NUM_SRC, // interrupt source count
  parameter NPIN = `PMC_NUM_PINS // external pin count
) (
  input wire sys_clk, // 200 mhz system clock
  input wire rst_b, // synchronous reset, active low
  input wire [7:0] avs_address, // register address
  input wire avs_read, // read strobe
  input wire avs_write, // write strobe
  input wire [31:0] avs_writedata, // write data
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // stall until answer
  input wire [NSRC-1:0] irq_event, // one-cycle source events
  input wire [NPIN-1:0] ext_interrupt_pin, // raw interrupt pins
  input wire port1_change_flag, // port1 pin change level
  output reg cpu_run, // cpu may execute
  output reg periph_clk_en, // timer0-2, uarts, adc clock
  output reg tmr3_clk_en, // timer3 clock enable
  output reg wdt_clk_en, // watchdog clock enable
  output reg fast_osc_en, // fast oscillator enable
  output reg slow_osc_en, // slow oscillator enable
  output reg fast_source_type, // 0 internal rc, 1 crystal
  output reg slow_source_type, // 0 internal rc, 1 crystal
  output reg fast_source_select, // 0 slow, 1 fast
  output reg [1:0] sysclk_divider, // applied divider code
  output reg sys_tick // divided system clock enable
);
  localparam ST_RUN = 4'h1; // fast or slow running
  localparam ST_IDLE = 4'h2; // cpu asleep
  localparam ST_HALT = 4'h4; // most clocks stopped
  localparam ST_STOP = 4'h8; // all but watchdog stopped

  reg [3:0] state_q; // mode state
  reg [3:0] state_d; // next mode
  reg [7:0] pwr_q; // power control register
  reg [7:0] clk_q; // clock control register
  reg [7:0] aux_q; // auxiliary control two
  reg [NPIN-1:0] wake_en_q; // ext_pin_wake_enable per pin
  reg [NSRC-1:0] flag_q; // pending interrupt flags
  reg [NSRC-1:0] int_en_q; // interrupt enables
  reg [NPIN-1:0] pin_s1_q; // pin sync first stage
  reg [NPIN-1:0] pin_s2_q; // pin sync second stage
  reg p1_s1_q; // port1 flag sync first stage
  reg p1_s2_q; // port1 flag sync second stage
  reg [4:0] psc_wait_q; // divider update delay
  reg [3:0] div_cnt_q; // divider counter
  reg ack_q; // read/write answer strobe
  reg [31:0] rd_d; // read data mux
  wire req; // bus access pending
  wire wr_now; // write takes effect
  wire fast_mode; // fast clock drives system
  wire fast_stop; // fast oscillator stop bit
  wire [NSRC-1:0] pending; // enabled and flagged
  wire [NSRC-1:0] pin_mask; // wake-capable sources
  wire pin_wake; // enabled pin wake event
  wire pin_block; // low pin with wake enabled
  wire wdt_on; // watchdog enabled in power down
  wire [7:0] wd; // low write byte
  integer i; // loop index

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q; // one wait state per access
  assign wr_now = avs_write & ack_q;
  assign wd = avs_writedata[7:0];
  assign fast_mode = clk_q[`PMC_BIT_FAST_SEL];
  assign fast_stop = clk_q[`PMC_BIT_FAST_STOP];
  assign wdt_on = aux_q[`PMC_BIT_WDT_HI] & aux_q[`PMC_BIT_WDT_LO];
  assign pending = flag_q & int_en_q;

  // mark the pin-served vectors; only these wake stop, while halt also wakes on timer3
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_pin
      assign pin_mask[g] = (g == `PMC_SRC_INT0) || (g == `PMC_SRC_INT1) ||
        (g == `PMC_SRC_PORT1) || (g == `PMC_SRC_INT29);
    end
  endgenerate

  // pin wake events need the source enabled too
  assign pin_wake = |(pending & pin_mask);
  // a held-low enabled pin would wake at once, so refuse entry
  assign pin_block = |(~pin_s2_q & wake_en_q);

  // answer strobe: every access gets exactly one wait cycle
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // two-flop synchronisers for pin levels from outside
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_s1_q <= {NPIN{1'b1}};
      pin_s2_q <= {NPIN{1'b1}};
      p1_s1_q <= 1'b0;
      p1_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= ext_interrupt_pin;
      pin_s2_q <= pin_s1_q;
      p1_s1_q <= port1_change_flag;
      p1_s2_q <= p1_s1_q;
    end
  end

  // interrupt flags: hardware sets win over software clears
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      flag_q <= {NSRC{1'b0}};
    end else begin
      for (i = 0; i < NSRC; i = i + 1) begin
        if (irq_event[i] || (i == `PMC_SRC_PORT1 && p1_s2_q)) begin
          flag_q[i] <= 1'b1;
        end else if (wr_now && avs_address == `PMC_OFS_INT_FLAG &&
                     avs_writedata[i]) begin
          flag_q[i] <= 1'b0; // write one to clear
        end
      end
    end
  end

  // simple enable registers
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      aux_q <= `PMC_RST_AUX_TWO;
      wake_en_q <= {NPIN{1'b0}};
      int_en_q <= {NSRC{1'b0}};
    end else if (wr_now) begin
      if (avs_address == `PMC_OFS_AUX_TWO) begin
        aux_q <= wd;
      end
      if (avs_address == `PMC_OFS_WAKE_EN) begin
        wake_en_q <= avs_writedata[NPIN-1:0];
      end
      if (avs_address == `PMC_OFS_INT_EN) begin
        int_en_q <= avs_writedata[NSRC-1:0];
      end
    end
  end

  // clock control: each field accepts writes only in its legal mode
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      clk_q <= `PMC_RST_CLK_CTRL;
    end else if (wr_now && avs_address == `PMC_OFS_CLK_CTRL) begin
      if (fast_mode) begin
        clk_q[`PMC_BIT_SLOW_TYPE] <= wd[`PMC_BIT_SLOW_TYPE];
      end
      if (!fast_mode) begin
        clk_q[`PMC_BIT_FAST_TYPE] <= wd[`PMC_BIT_FAST_TYPE];
        clk_q[`PMC_BIT_FAST_STOP] <= wd[`PMC_BIT_FAST_STOP];
      end
      // stop and select may not both end up set
      if (!fast_stop && !(wd[`PMC_BIT_FAST_SEL] && wd[`PMC_BIT_FAST_STOP])) begin
        clk_q[`PMC_BIT_FAST_SEL] <= wd[`PMC_BIT_FAST_SEL];
      end
      clk_q[`PMC_BIT_SLOW_STOP] <= wd[`PMC_BIT_SLOW_STOP];
      clk_q[`PMC_BIT_PCLK_GATE] <= wd[`PMC_BIT_PCLK_GATE];
      clk_q[1:0] <= wd[1:0];
    end
  end

  // divider code reaches the counter after a fixed settle delay
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      psc_wait_q <= 5'h00;
      sysclk_divider <= `PMC_PSC_DIV1;
    end else if (wr_now && avs_address == `PMC_OFS_CLK_CTRL) begin
      psc_wait_q <= `PMC_PSC_DELAY;
    end else if (psc_wait_q != 5'h00) begin
      psc_wait_q <= psc_wait_q - 5'h01;
      if (psc_wait_q == 5'h01) begin
        sysclk_divider <= clk_q[1:0];
      end
    end else begin
      sysclk_divider <= clk_q[1:0];
    end
  end

  // divided system clock as a one-cycle enable pulse
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      div_cnt_q <= 4'h0;
      sys_tick <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
      case (sysclk_divider)
        `PMC_PSC_DIV16: sys_tick <= (div_cnt_q == 4'hF);
        `PMC_PSC_DIV4: sys_tick <= (div_cnt_q[1:0] == 2'h3);
        `PMC_PSC_DIV2: sys_tick <= div_cnt_q[0];
        default: sys_tick <= 1'b1;
      endcase
    end
  end

  // mode sequencing
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (pwr_q[`PMC_BIT_PDOWN] && !pin_block) begin
          if (clk_q[`PMC_BIT_SLOW_STOP]) begin
            state_d = ST_STOP;
          end else begin
            state_d = ST_HALT;
          end
        end else if (pwr_q[`PMC_BIT_IDLE]) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (|pending) begin
          state_d = ST_RUN;
        end
      end
      ST_HALT: begin
        if (pin_wake || pending[`PMC_SRC_TMR3]) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (pin_wake) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // state register and power control; reset ends every mode
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
      pwr_q <= `PMC_RST_PWR_CTRL;
    end else begin
      state_q <= state_d;
      if (state_q != ST_RUN && state_d == ST_RUN) begin
        pwr_q[1:0] <= 2'h0;
      end else if (state_q == ST_RUN && pwr_q[`PMC_BIT_PDOWN] && pin_block) begin
        pwr_q[`PMC_BIT_PDOWN] <= 1'b0; // refused entry drops request
      end else if (wr_now && avs_address == `PMC_OFS_PWR_CTRL) begin
        pwr_q <= wd & 8'h8F;
      end
    end
  end

  // clock gating outputs from the mode
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      cpu_run <= 1'b1;
      periph_clk_en <= 1'b1;
      tmr3_clk_en <= 1'b1;
      wdt_clk_en <= 1'b1;
      fast_osc_en <= 1'b1;
      slow_osc_en <= 1'b1;
      fast_source_type <= 1'b0;
      slow_source_type <= 1'b0;
      fast_source_select <= 1'b0;
    end else begin
      cpu_run <= (state_d == ST_RUN);
      periph_clk_en <= (state_d == ST_RUN) || (state_d == ST_IDLE &&
        !clk_q[`PMC_BIT_PCLK_GATE]);
      tmr3_clk_en <= (state_d != ST_STOP);
      wdt_clk_en <= (state_d == ST_RUN || state_d == ST_IDLE) || wdt_on;
      fast_osc_en <= !(fast_stop && !fast_mode) && (state_d == ST_RUN ||
        state_d == ST_IDLE);
      slow_osc_en <= (state_d != ST_STOP);
      fast_source_type <= clk_q[`PMC_BIT_FAST_TYPE];
      slow_source_type <= clk_q[`PMC_BIT_SLOW_TYPE];
      fast_source_select <= fast_mode;
    end
  end

  // read multiplexer; unmapped addresses read zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (avs_address)
      `PMC_OFS_PWR_CTRL: rd_d[7:0] = pwr_q;
      `PMC_OFS_CLK_CTRL: rd_d[7:0] = clk_q;
      `PMC_OFS_AUX_TWO: rd_d[7:0] = aux_q;
      `PMC_OFS_STATUS: rd_d[5:0] = {sysclk_divider, state_q};
      `PMC_OFS_WAKE_EN: rd_d[NPIN-1:0] = wake_en_q;
      `PMC_OFS_INT_FLAG: rd_d[NSRC-1:0] = flag_q;
      `PMC_OFS_INT_EN: rd_d[NSRC-1:0] = int_en_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read data registered at the answer edge
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rd_d;
    end
  end
endmodule // pmc_top
`default_nettype wire

// ===== testbench/pmc_assertions.sv
// checker for the power mode clock controller ports
`timescale 1ns/10ps
`default_nettype none
module pmc_checker #(
  parameter NSRC = 14, // interrupt source count
  parameter NPIN = 10 // external pin count
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [7:0] avs_address, // register address
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic avs_waitrequest, // bus stall
  input wire logic cpu_run, // cpu may execute
  input wire logic periph_clk_en, // peripheral clock enable
  input wire logic tmr3_clk_en, // timer3 clock enable
  input wire logic fast_osc_en, // fast oscillator enable
  input wire logic slow_osc_en, // slow oscillator enable
  input wire logic fast_source_type, // fast type bit
  input wire logic slow_source_type, // slow type bit
  input wire logic fast_source_select, // source select bit
  input wire logic [1:0] sysclk_divider, // applied divider
  input wire logic sys_tick // divided tick
);
  // one domain, so clock and reset are given once here
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // gating peripherals is only legal with the cpu asleep
  idle_gate_a: assert property (!periph_clk_en |-> !cpu_run)
    else $error("peripheral clock gated while cpu runs");
  tmr3_gate_a: assert property (!tmr3_clk_en |-> !cpu_run && !periph_clk_en)
    else $error("timer3 clock stopped outside stop mode");
  slow_stop_a: assert property (!slow_osc_en |-> !tmr3_clk_en)
    else $error("slow oscillator off while timer3 clocked");
  fast_off_a: assert property (!fast_osc_en && cpu_run |-> !fast_source_select)
    else $error("fast oscillator off while selected");
  slow_type_a: assert property ($changed(slow_source_type) |-> $past(fast_source_select))
    else $error("slow type changed in slow mode");
  fast_type_a: assert property ($changed(fast_source_type) |-> !$past(fast_source_select))
    else $error("fast type changed in fast mode");
  // idle request must stop the cpu within a few cycles
  idle_entry_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'h87
    && avs_writedata[0] && cpu_run |-> ##[1:3] !cpu_run) else $error("idle not entered");
  div_one_a: assert property (sysclk_divider == 2'h3 [*3] |-> sys_tick)
    else $error("divide by one tick missing");
  div_two_a: assert property (sysclk_divider == 2'h2 [*3] ##0 sys_tick |=> !sys_tick)
    else $error("divide by two ticks too close");
endmodule // pmc_checker
bind pmc_top pmc_checker #(.NSRC(NSRC), .NPIN(NPIN)) u_chk (.sys_clk(sys_clk),
  .rst_b(rst_b), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .cpu_run(cpu_run), .periph_clk_en(periph_clk_en), .tmr3_clk_en(tmr3_clk_en),
  .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
  .fast_source_type(fast_source_type), .slow_source_type(slow_source_type),
  .fast_source_select(fast_source_select), .sysclk_divider(sysclk_divider),
  .sys_tick(sys_tick));
`default_nettype wire

// ===== testbench/tb.sv
// self-checking testbench for the power mode clock controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0; // 200 mhz clock
  logic rst_b = 1'b0; // held low at start
  logic [7:0] addr = 8'h00; // bus address
  logic rd = 1'b0; // read strobe
  logic wr = 1'b0; // write strobe
  logic [31:0] wdata = 32'h0; // write data
  logic [13:0] ev = 14'h0; // source event pulses
  logic [9:0] pins = 10'h3FF; // pins idle high
  logic p1 = 1'b0; // port1 change level
  wire [31:0] rdata; // read data
  wire wreq; // waitrequest
  wire cpu_run, periph_clk_en, tmr3_clk_en, fast_osc_en, slow_osc_en;
  wire wdt_clk_en, fast_source_select; // watchdog clock, source select
  wire [1:0] sysclk_divider; // applied divider
  integer err_total = 0; // mismatch count
  integer total_checks = 0; // comparison count
  integer i, cnt; // loop helpers
  always #2.5 sys_clk = ~sys_clk;
  pmc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .irq_event(ev), .ext_interrupt_pin(pins),
    .port1_change_flag(p1), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
    .tmr3_clk_en(tmr3_clk_en), .wdt_clk_en(wdt_clk_en),
    .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
    .fast_source_type(), .slow_source_type(),
    .fast_source_select(fast_source_select),
    .sysclk_divider(sysclk_divider), .sys_tick());
  // the single place where the run ends
  task end_sim;
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one avalon access; held until waitrequest is seen low at an edge
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    integer n;
    n = 0;
    @(posedge sys_clk);
    addr <= a; rd <= !w; wr <= w; wdata <= d;
    do begin
      @(posedge sys_clk);
      n = n + 1;
      if (n > 50) begin
        err_total = err_total + 1;
        end_sim;
      end
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task pulse(input integer s);
    @(posedge sys_clk); ev <= 14'h1 << s;
    @(posedge sys_clk); ev <= 14'h0;
  endtask
  // bounded wait for the cpu run state, mismatch if it never comes
  task wait_run(input v);
    integer n;
    for (n = 0; n < 20 && cpu_run !== v; n = n + 1) @(posedge sys_clk);
    chk(cpu_run, v);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk(sysclk_divider, 2'h3);
    rchk(8'hD8, 32'h23);
    rchk(8'h10, 32'h0);
    // clock control write permissions, legal and refused
    wreg(8'hD8, 32'h63); rchk(8'hD8, 32'h63);
    wreg(8'hD8, 32'hE3); rchk(8'hD8, 32'h63);
    // crystal type first, then select; oscillator settling is not modelled
    wreg(8'hD8, 32'h67); rchk(8'hD8, 32'h67);
    chk(fast_source_select, 1'b1);
    wreg(8'hD8, 32'h6F); rchk(8'hD8, 32'h67);
    wreg(8'hD8, 32'hE7); rchk(8'hD8, 32'hE7);
    wreg(8'hD8, 32'h63); wreg(8'hD8, 32'h6B); rchk(8'hD8, 32'h6B);
    chk(fast_osc_en, 1'b0);
    wreg(8'hD8, 32'h6F); rchk(8'hD8, 32'h6B);
    // every divider code, tick count over 32 cycles
    for (i = 0; i < 4; i = i + 1) begin
      wreg(8'hD8, 32'h20 | i);
      repeat (17) @(posedge sys_clk);
      chk(sysclk_divider, i);
      cnt = 0;
      repeat (32) begin
        @(posedge sys_clk);
        if (dut.sys_tick === 1'b1) cnt = cnt + 1;
      end
      chk(cnt, (i == 0) ? 2 : (i == 1) ? 8 : (i == 2) ? 16 : 32);
    end
    wreg(8'hD8, 32'h23);
    wreg(8'hEC, 32'h83); wreg(8'hE4, 32'h1);
    // idle: disabled source only flags, enabled one wakes
    wreg(8'h87, 32'h1); wait_run(1'b0);
    chk(periph_clk_en, 1'b1);
    pulse(3); repeat (5) @(posedge sys_clk);
    chk(cpu_run, 1'b0);
    pulse(1); wait_run(1'b1);
    rchk(8'h87, 32'h0);
    rchk(8'hE8, 32'hA);
    wreg(8'hE8, 32'h3FFF);
    // idle with peripheral gate
    wreg(8'hD8, 32'h33); wreg(8'h87, 32'h1); wait_run(1'b0);
    chk(periph_clk_en, 1'b0); chk(tmr3_clk_en, 1'b1);
    pulse(1); wait_run(1'b1);
    // halt, woken by timer3
    wreg(8'hF7, 32'hC0); // watchdog kept alive in power-down
    wreg(8'hD8, 32'h03); wreg(8'hE8, 32'h3FFF); wreg(8'h87, 32'h2);
    wait_run(1'b0);
    chk(tmr3_clk_en, 1'b1); chk(periph_clk_en, 1'b0);
    chk(wdt_clk_en, 1'b1);
    pulse(7); wait_run(1'b1);
    // stop ignores timer3, wakes on pin source
    wreg(8'hF7, 32'h00); // watchdog disabled: nothing stays clocked
    wreg(8'hD8, 32'h23);
    wreg(8'hE8, 32'h3FFF); wreg(8'h87, 32'h2);
    wait_run(1'b0);
    chk(slow_osc_en, 1'b0); chk(tmr3_clk_en, 1'b0);
    chk(wdt_clk_en, 1'b0);
    rchk(8'hE0, 32'h38);
    pulse(7); repeat (5) @(posedge sys_clk);
    chk(cpu_run, 1'b0);
    pulse(0); wait_run(1'b1);
    rchk(8'h87, 32'h0);
    // low pin with wake enabled refuses power-down
    wreg(8'hE8, 32'h3FFF);
    pins <= 10'h3FE; repeat (4) @(posedge sys_clk);
    wreg(8'h87, 32'h2); repeat (5) @(posedge sys_clk);
    chk(cpu_run, 1'b1);
    rchk(8'h87, 32'h0);
    end_sim;
  end
  // hang guard
  initial begin
    #200000;
    err_total = err_total + 1;
    end_sim;
  end
endmodule // tb
`default_nettype wire
